// ---- hw/dmac_pkg.sv ----
`default_nettype none
package dmac_pkg;
    // controller and channel counts
    localparam int NUM_CTL    = 2;
    localparam int CH_PER_CTL = 6;
    localparam int NUM_CH     = NUM_CTL * CH_PER_CTL;
    localparam int MAX_COUNT  = 65536;
    localparam int CNT_W      = 17;
    // register byte offsets
    localparam logic [11:0] STAT_OFS   = 12'h000;
    localparam logic [11:0] CLR_OFS    = 12'h008;
    localparam logic [11:0] IEN_OFS    = 12'h010;
    localparam logic [11:0] GEN_OFS    = 12'h040;
    localparam logic [11:0] CH_OFS     = 12'h100;
    localparam logic [11:0] CH_STRIDE  = 12'h020;
    localparam logic [4:0]  CFG_OFS    = 5'h00;
    localparam logic [4:0]  SRC_OFS    = 5'h04;
    localparam logic [4:0]  DST_OFS    = 5'h08;
    localparam logic [4:0]  CNT_OFS    = 5'h0C;
    localparam logic [4:0]  ROUTE_OFS  = 5'h10;
    // channel config fields
    localparam int CFG_EN   = 0;
    localparam int CFG_SW   = 1;
    localparam int CFG_CIRC = 2;
    localparam int CFG_PRIO = 3;
    localparam int CFG_SSZ  = 5;
    localparam int CFG_DSZ  = 7;
    localparam int CFG_SINC = 9;
    localparam int CFG_DINC = 10;
    // route fields
    localparam int RT_SEL    = 0;
    localparam int RT_SYNCEN = 8;
    localparam int RT_SYNSEL = 9;
    // generator fields
    localparam int GEN_EN   = 0;
    localparam int GEN_TSEL = 1;
    localparam int GEN_NB   = 4;
    localparam int GEN_CNT  = 16;
    // flag bits inside each channel nibble
    localparam int FL_HT = 0;
    localparam int FL_TC = 1;
    localparam int FL_TE = 2;
    // element size codes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    // reset value of all software state
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    // engine states
    typedef enum logic [2:0] {
        ENG_IDLE  = 3'b001,
        ENG_READ  = 3'b010,
        ENG_WRITE = 3'b100
    } dmac_eng_t;
endpackage
`default_nettype wire

// ---- hw/dmac_arb.sv ----
`default_nettype none
module dmac_arb #(
    parameter int N = 6
) (
    // pending channels and their levels
    input  wire logic [N-1:0]      pend,
    input  wire logic [N-1:0][1:0] prio,
    // winner
    output logic                   valid,
    output logic [2:0]             idx
);
    // index is three bits wide
    if (N < 1 || N > 8) begin : g_bad
        $error("dmac_arb: N must be 1..8");
    end

    logic [1:0] best; // level of current winner

    // scan upward and take only a strictly higher level, so ties keep the lower index
    always_comb begin
        valid = 1'b0;
        idx   = 3'h0;
        best  = 2'h0;
        for (int i = 0; i < N; i++) begin
            if (pend[i] && (!valid || prio[i] > best)) begin
                valid = 1'b1;
                idx   = 3'(i);
                best  = prio[i];
            end
        end
    end
endmodule
`default_nettype wire

// ---- hw/dmac_top.sv ----
// Summary of operation
// - two controllers, six channels each, twelve total
// - each controller has its own arbiter
// - four software priority levels, higher served first
// - equal priority: lower channel number wins
// - hardware request or software trigger per channel
// - independent byte/half/word sizes, narrow side cuts, wide side pads with zeros
// - circular mode reloads address and count
// - three flags per channel ORed into interrupt
// - any memory/peripheral source and destination pairing
// - master reaches any address on system bus
// - element count programmable up to 65536
// - request pending until served and line drops
// - router selects source, optionally gated by sync
// - request generator fires on trigger events
`default_nettype none
module dmac_top #(
    parameter int NREQ  = 16,
    parameter int NSYNC = 4,
    parameter int NTRIG = 4,
    parameter int NGEN  = 4
) (
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    reset_n,
    // wishbone slave
    input  wire logic                    wbCyc,
    input  wire logic                    wbStb,
    input  wire logic                    wbWe,
    input  wire logic [11:0]             wbAdr,
    input  wire logic [3:0]              wbSel,
    input  wire logic [31:0]             wbDatI,
    output logic [31:0]                  wbDatO,
    output logic                         wbAck,
    // requesting side
    input  wire logic [NREQ-1:0]         periphReq,
    input  wire logic [NSYNC-1:0]        syncIn,
    input  wire logic [NTRIG-1:0]        trigIn,
    output logic [dmac_pkg::NUM_CH-1:0]  chanAck,
    // system bus masters, one per controller
    output logic [1:0]                   memReq,
    output logic [1:0]                   memWe,
    output logic [1:0][1:0]              memSize,
    output logic [1:0][31:0]             memAddr,
    output logic [1:0][31:0]             memWdata,
    input  wire logic [1:0][31:0]        memRdata,
    input  wire logic [1:0]              memAck,
    input  wire logic [1:0]              memErr,
    // interrupts
    output logic [dmac_pkg::NUM_CH-1:0]  chanIrq,
    output logic                         irq
);
    localparam int NCH = dmac_pkg::NUM_CH;
    localparam int CPC = dmac_pkg::CH_PER_CTL;
    localparam logic [11:0] CH_END  = 12'(dmac_pkg::CH_OFS + NCH * dmac_pkg::CH_STRIDE);
    localparam logic [11:0] GEN_END = 12'(dmac_pkg::GEN_OFS + NGEN * 4);

    // route select is five bits; sync and trigger selects two bits
    if (NREQ < 1 || NGEN < 1 || NREQ + NGEN > 32 || NSYNC < 1 || NSYNC > 4
        || NTRIG < 1 || NTRIG > 4) begin : g_bad
        $error("dmac_top: unsupported source counts");
    end

    typedef struct packed {
        logic [NCH-1:0]            en;      // channel enabled
        logic [NCH-1:0]            sw;      // software trigger
        logic [NCH-1:0]            circ;    // circular mode
        logic [NCH-1:0]            sInc;    // source increments
        logic [NCH-1:0]            dInc;    // destination increments
        logic [NCH-1:0]            syncEn;  // forward only after sync event
        logic [NCH-1:0]            served;  // waiting for request to drop
        logic [NCH-1:0]            armed;   // sync event seen
        logic [NCH-1:0]            ack;     // element done pulse
        logic [NCH-1:0][1:0]       prio;
        logic [NCH-1:0][1:0]       sSz;
        logic [NCH-1:0][1:0]       dSz;
        logic [NCH-1:0][1:0]       syncSel;
        logic [NCH-1:0][4:0]       reqSel;
        logic [NCH-1:0][31:0]      src;
        logic [NCH-1:0][31:0]      dst;
        logic [NCH-1:0][31:0]      curS;
        logic [NCH-1:0][31:0]      curD;
        logic [NCH-1:0][16:0]      cnt;     // programmed count
        logic [NCH-1:0][16:0]      rem;     // remaining count
        logic [NCH-1:0][2:0]       flag;    // te tc ht
        logic [NCH-1:0][2:0]       ien;
        logic [NGEN-1:0]           gEn;
        logic [NGEN-1:0]           gHold;   // one-cycle drop after consume
        logic [NGEN-1:0][1:0]      gSel;
        logic [NGEN-1:0][4:0]      gNb;
        logic [NGEN-1:0][5:0]      gCnt;
        logic [NSYNC-1:0]          syncPrev;
        logic [NTRIG-1:0]          trigPrev;
        dmac_pkg::dmac_eng_t [1:0] eng;
        logic [1:0][2:0]           gnt;     // channel inside controller
        logic [1:0][31:0]          data;
        logic [1:0][31:0]          addr;
        logic [1:0][1:0]           size;
        logic                      wbAck;
        logic [31:0]               wbDat;
    } dmac_st_t;

    dmac_st_t          q;         // registered state
    dmac_st_t          n;         // next state
    logic [31:0]       srcVec;    // all request sources
    logic [NGEN-1:0]   genReq;    // generator request lines
    logic [NCH-1:0]    fwd;       // routed request after sync gate
    logic [NCH-1:0]    pend;      // channel wants service
    logic [3:0]        syncRise;
    logic [3:0]        trigRise;
    logic [1:0]        arbValid;
    logic [1:0][2:0]   arbIdx;

    // merge bytes under the wishbone select
    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) r[b*8 +: 8] = d[b*8 +: 8];
        end
        return r;
    endfunction

    // address step for one element
    function automatic logic [31:0] szBytes(input logic [1:0] s);
        case (s)
            dmac_pkg::SZ_BYTE: szBytes = 32'h0000_0001;
            dmac_pkg::SZ_HALF: szBytes = 32'h0000_0002;
            default:           szBytes = 32'h0000_0004;
        endcase
    endfunction

    // data bits valid for one element
    function automatic logic [31:0] szMask(input logic [1:0] s);
        case (s)
            dmac_pkg::SZ_BYTE: szMask = 32'h0000_00FF;
            dmac_pkg::SZ_HALF: szMask = 32'h0000_FFFF;
            default:           szMask = 32'hFFFF_FFFF;
        endcase
    endfunction

    // event edges; inputs come from logic on this clock
    assign syncRise = 4'(syncIn & ~q.syncPrev);
    assign trigRise = 4'(trigIn & ~q.trigPrev);

    // generator lines join the peripheral lines as extra sources
    for (genvar g = 0; g < NGEN; g++) begin : g_gen
        assign genReq[g] = (q.gCnt[g] != 6'h00) & ~q.gHold[g];
    end
    assign srcVec = 32'({genReq, periphReq});

    // per channel routing and pending
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        assign fwd[i]  = srcVec[q.reqSel[i]] & (~q.syncEn[i] | q.armed[i]);
        assign pend[i] = q.en[i] & (q.rem[i] != 17'h0_0000)
                       & (q.sw[i] | (fwd[i] & ~q.served[i]));
        assign chanIrq[i] = |(q.flag[i] & q.ien[i]);
    end

    // one arbiter per controller; router outputs 0-5 and 6-11 split here
    for (genvar c = 0; c < dmac_pkg::NUM_CTL; c++) begin : g_ctl
        dmac_arb #(.N(CPC)) u_arb (
            .pend  (pend[c*CPC +: CPC]),
            .prio  (q.prio[c*CPC +: CPC]),
            .valid (arbValid[c]),
            .idx   (arbIdx[c])
        );
    end

    // next-state logic: bus first, engines last so hardware sets win
    always_comb begin
        logic [31:0] rd;
        logic [31:0] w;
        logic [31:0] cfgW;
        logic [11:0] rel;
        logic [63:0] fl;
        logic [63:0] ie;
        logic [16:0] nr;
        int          ch;
        int          g;
        rd   = '0;
        w    = '0;
        cfgW = '0;
        rel  = wbAdr - dmac_pkg::CH_OFS;
        fl   = '0;
        ie   = '0;
        nr   = '0;
        ch   = 0;
        g    = 0;
        n          = q;
        n.ack      = '0;
        n.gHold    = '0;
        n.wbAck    = 1'b0;
        n.syncPrev = syncIn;
        n.trigPrev = trigIn;
        // flatten flags, one nibble per channel
        for (int i = 0; i < NCH; i++) begin
            fl[i*4 +: 4] = {1'b0, q.flag[i]};
            ie[i*4 +: 4] = {1'b0, q.ien[i]};
            // line dropped: next assertion is a new request
            if (!srcVec[q.reqSel[i]]) n.served[i] = 1'b0;
            if (q.syncEn[i] && syncRise[q.syncSel[i]]) n.armed[i] = 1'b1;
        end
        // trigger loads a burst; overlapping triggers are dropped
        for (int k = 0; k < NGEN; k++) begin
            if (q.gEn[k] && trigRise[q.gSel[k]] && q.gCnt[k] == 6'h00) begin
                n.gCnt[k] = {1'b0, q.gNb[k]} + 6'h01;
            end
        end
        // wishbone access, answered one cycle after it is seen
        if (wbCyc && wbStb && !q.wbAck) begin
            n.wbAck = 1'b1;
            if (wbAdr >= dmac_pkg::CH_OFS && wbAdr < CH_END) begin
                ch   = int'(rel[8:5]);
                cfgW = {21'h0, q.dInc[ch], q.sInc[ch], q.dSz[ch], q.sSz[ch],
                        q.prio[ch], q.circ[ch], q.sw[ch], q.en[ch]};
                case (rel[4:0])
                    dmac_pkg::CFG_OFS: begin
                        rd = cfgW;
                        w  = wmerge(cfgW, wbDatI, wbSel);
                        if (wbWe) begin
                            n.en[ch]   = w[dmac_pkg::CFG_EN];
                            n.sw[ch]   = w[dmac_pkg::CFG_SW];
                            n.circ[ch] = w[dmac_pkg::CFG_CIRC];
                            n.prio[ch] = w[dmac_pkg::CFG_PRIO +: 2];
                            n.sSz[ch]  = w[dmac_pkg::CFG_SSZ +: 2];
                            n.dSz[ch]  = w[dmac_pkg::CFG_DSZ +: 2];
                            n.sInc[ch] = w[dmac_pkg::CFG_SINC];
                            n.dInc[ch] = w[dmac_pkg::CFG_DINC];
                            // enabling starts from the programmed values
                            if (w[dmac_pkg::CFG_EN] && !q.en[ch]) begin
                                n.curS[ch]   = q.src[ch];
                                n.curD[ch]   = q.dst[ch];
                                n.rem[ch]    = q.cnt[ch];
                                n.served[ch] = 1'b0;
                                n.armed[ch]  = 1'b0;
                            end
                        end
                    end
                    // address and count are locked while enabled
                    dmac_pkg::SRC_OFS: begin
                        rd = q.src[ch];
                        if (wbWe && !q.en[ch]) n.src[ch] = wmerge(q.src[ch], wbDatI, wbSel);
                    end
                    dmac_pkg::DST_OFS: begin
                        rd = q.dst[ch];
                        if (wbWe && !q.en[ch]) n.dst[ch] = wmerge(q.dst[ch], wbDatI, wbSel);
                    end
                    dmac_pkg::CNT_OFS: begin
                        rd = {15'h0, q.rem[ch]};
                        w  = wmerge({15'h0, q.cnt[ch]}, wbDatI, wbSel);
                        if (wbWe && !q.en[ch]) begin
                            // larger values saturate at the maximum
                            n.cnt[ch] = (w > dmac_pkg::MAX_COUNT)
                                      ? 17'(dmac_pkg::MAX_COUNT) : w[16:0];
                        end
                    end
                    dmac_pkg::ROUTE_OFS: begin
                        rd = {21'h0, q.syncSel[ch], q.syncEn[ch], 3'h0, q.reqSel[ch]};
                        w  = wmerge(rd, wbDatI, wbSel);
                        if (wbWe) begin
                            n.reqSel[ch]  = w[dmac_pkg::RT_SEL +: 5];
                            n.syncEn[ch]  = w[dmac_pkg::RT_SYNCEN];
                            n.syncSel[ch] = w[dmac_pkg::RT_SYNSEL +: 2];
                        end
                    end
                    default: rd = '0;
                endcase
            end else if (wbAdr >= dmac_pkg::GEN_OFS && wbAdr < GEN_END) begin
                g  = int'(wbAdr[5:2]) - int'(dmac_pkg::GEN_OFS[5:2]);
                rd = {10'h0, q.gCnt[g], 7'h0, q.gNb[g], 1'b0, q.gSel[g], q.gEn[g]};
                w  = wmerge(rd, wbDatI, wbSel);
                if (wbWe) begin
                    n.gEn[g]  = w[dmac_pkg::GEN_EN];
                    n.gSel[g] = w[dmac_pkg::GEN_TSEL +: 2];
                    n.gNb[g]  = w[dmac_pkg::GEN_NB +: 5];
                end
            end else begin
                case (wbAdr)
                    dmac_pkg::STAT_OFS:         rd = fl[31:0];
                    dmac_pkg::STAT_OFS + 12'h4: rd = fl[63:32];
                    dmac_pkg::IEN_OFS:          rd = ie[31:0];
                    dmac_pkg::IEN_OFS + 12'h4:  rd = ie[63:32];
                    default:                    rd = '0;
                endcase
                // clear register: ones clear, reads as zero
                if (wbWe && wbAdr == dmac_pkg::CLR_OFS)
                    fl[31:0] = wmerge(32'h0, wbDatI, wbSel);
                else if (wbWe && wbAdr == dmac_pkg::CLR_OFS + 12'h4)
                    fl[63:32] = wmerge(32'h0, wbDatI, wbSel);
                else
                    fl = '0;
                if (wbWe && wbAdr == dmac_pkg::IEN_OFS)
                    ie[31:0] = wmerge(ie[31:0], wbDatI, wbSel);
                if (wbWe && wbAdr == dmac_pkg::IEN_OFS + 12'h4)
                    ie[63:32] = wmerge(ie[63:32], wbDatI, wbSel);
                for (int i = 0; i < NCH; i++) begin
                    n.flag[i] = q.flag[i] & ~fl[i*4 +: 3];
                    n.ien[i]  = ie[i*4 +: 3];
                end
            end
            n.wbDat = rd;
        end
        // transfer engines: one read then one write per element
        for (int c = 0; c < dmac_pkg::NUM_CTL; c++) begin
            ch = c * CPC + int'(q.gnt[c]);
            case (q.eng[c])
                dmac_pkg::ENG_IDLE: begin
                    if (arbValid[c]) begin
                        n.gnt[c]  = arbIdx[c];
                        ch        = c * CPC + int'(arbIdx[c]);
                        n.addr[c] = q.curS[ch];
                        n.size[c] = q.sSz[ch];
                        n.eng[c]  = dmac_pkg::ENG_READ;
                    end
                end
                dmac_pkg::ENG_READ: begin
                    if (memErr[c]) begin
                        n.flag[ch][dmac_pkg::FL_TE] = 1'b1;
                        n.en[ch]  = 1'b0;
                        n.eng[c]  = dmac_pkg::ENG_IDLE;
                    end else if (memAck[c]) begin
                        // narrow side cuts, wide side pads with zeros
                        n.data[c] = memRdata[c] & szMask(q.sSz[ch]) & szMask(q.dSz[ch]);
                        n.addr[c] = q.curD[ch];
                        n.size[c] = q.dSz[ch];
                        n.eng[c]  = dmac_pkg::ENG_WRITE;
                    end
                end
                dmac_pkg::ENG_WRITE: begin
                    if (memErr[c]) begin
                        n.flag[ch][dmac_pkg::FL_TE] = 1'b1;
                        n.en[ch]  = 1'b0;
                        n.eng[c]  = dmac_pkg::ENG_IDLE;
                    end else if (memAck[c]) begin
                        n.eng[c]  = dmac_pkg::ENG_IDLE;
                        nr        = q.rem[ch] - 17'h0_0001;
                        n.rem[ch] = nr;
                        n.ack[ch] = 1'b1;
                        if (!q.sw[ch]) n.served[ch] = 1'b1;
                        n.armed[ch] = 1'b0;
                        // addresses step by their own size; alignment is software's job
                        if (q.sInc[ch]) n.curS[ch] = q.curS[ch] + szBytes(q.sSz[ch]);
                        if (q.dInc[ch]) n.curD[ch] = q.curD[ch] + szBytes(q.dSz[ch]);
                        // generator source consumed one request
                        if (int'(q.reqSel[ch]) >= NREQ && int'(q.reqSel[ch]) < NREQ + NGEN
                            && !q.sw[ch]) begin
                            g = int'(q.reqSel[ch]) - NREQ;
                            if (n.gCnt[g] != 6'h00) n.gCnt[g] = n.gCnt[g] - 6'h01;
                            n.gHold[g] = 1'b1;
                        end
                        if (nr == (q.cnt[ch] >> 1)) n.flag[ch][dmac_pkg::FL_HT] = 1'b1;
                        if (nr == 17'h0_0000) begin
                            n.flag[ch][dmac_pkg::FL_TC] = 1'b1;
                            if (q.circ[ch]) begin
                                n.curS[ch] = q.src[ch];
                                n.curD[ch] = q.dst[ch];
                                n.rem[ch]  = q.cnt[ch];
                            end else begin
                                n.en[ch] = 1'b0;
                            end
                        end
                    end
                end
                default: n.eng[c] = dmac_pkg::ENG_IDLE;
            endcase
        end
    end

    // state register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            q       <= dmac_st_t'(dmac_pkg::REG_RST);
            q.eng   <= {dmac_pkg::ENG_IDLE, dmac_pkg::ENG_IDLE};
        end else begin
            q <= n;
        end
    end

    // outputs
    assign wbAck    = q.wbAck;
    assign wbDatO   = q.wbDat;
    assign chanAck  = q.ack;
    assign memAddr  = q.addr;
    assign memWdata = q.data;
    assign memSize  = q.size;
    assign irq      = |chanIrq;
    for (genvar c = 0; c < dmac_pkg::NUM_CTL; c++) begin : g_mem
        assign memReq[c] = q.eng[c] != dmac_pkg::ENG_IDLE;
        assign memWe[c]  = q.eng[c] == dmac_pkg::ENG_WRITE;
    end
endmodule
`default_nettype wire

// ---- sim/dmac_assertions.sv ----
`default_nettype none
module dmac_chk (
    // clock, reset and bus
    input wire logic             mclk,
    input wire logic             reset_n,
    input wire logic             wbCyc,
    input wire logic             wbStb,
    input wire logic             wbAck,
    // masters and channels
    input wire logic [1:0]       memReq,
    input wire logic [1:0]       memWe,
    input wire logic [1:0][31:0] memAddr,
    input wire logic [1:0]       memAck,
    input wire logic [1:0]       memErr,
    input wire logic [11:0]      chanAck,
    input wire logic [11:0]      chanIrq,
    input wire logic             irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    chk_ack_next: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
        else $error("bus answer late");
    chk_ack_pulse: assert property (wbAck |=> !wbAck)
        else $error("bus answer too long");
    chk_irq_or: assert property (irq == (|chanIrq))
        else $error("irq not or of channels");
    chk_req_hold: assert property (memReq[0] && !memAck[0] && !memErr[0]
        |=> memReq[0] && $stable(memAddr[0])) else $error("request dropped early");
    chk_read_write: assert property (memReq[1] && !memWe[1] && memAck[1]
        |=> memReq[1] && memWe[1]) else $error("write does not follow read");
    chk_done_first: assert property (memReq[0] && memWe[0] && memAck[0]
        |=> !memReq[0] && (|chanAck[5:0])) else $error("first done wrong");
    chk_done_second: assert property (memReq[1] && memWe[1] && memAck[1]
        |=> !memReq[1] && (|chanAck[11:6]) ##1 !(|chanAck[11:6])) else $error("second done wrong");
    chk_one_winner: assert property ($onehot0(chanAck[5:0]) && $onehot0(chanAck[11:6]))
        else $error("two channels served at once");
    // main scenarios reached
    cover property (memAck[1] && memWe[1]);
    cover property (irq);
    cover property (chanAck[8]);
endmodule
bind dmac_top dmac_chk u_chk (.mclk, .reset_n, .wbCyc, .wbStb, .wbAck, .memReq, .memWe,
    .memAddr, .memAck, .memErr, .chanAck, .chanIrq, .irq);
`default_nettype wire

// ---- sim/dmac_mem_model.sv ----
`default_nettype none
module dmac_mem_model #(
    parameter int LAT = 0
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // one master port, word wide
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    output logic [31:0]      rdata,
    output logic             ack,
    output logic             err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [256]; // preloaded so reads are predictable
    int          waited;    // idle cycles seen on this request
    initial for (int i = 0; i < 256; i++) mem[i] = 32'hC0DE0000 + i;
    // answer after LAT cycles; address bit 31 marks a faulting place
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            {ack, err, waited, rdata} <= '0;
        end else if (req && !ack && !err && waited >= LAT) begin
            ack <= !addr[31];
            err <= addr[31];
            waited <= 0;
            rdata <= mem[addr[9:2]];
            if (we && !addr[31]) mem[addr[9:2]] <= wdata;
        end else begin
            {ack, err} <= 2'b00;
            rdata <= ~rdata; // stale data never looks valid
            waited <= req ? waited + 1 : 0;
        end
    end
endmodule
`default_nettype wire

// ---- sim/dmac_top_tb.sv ----
`default_nettype none
module dmac_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic             mclk = 1'b0, reset_n = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic             wbAck, irq;
    logic [11:0]      wbAdr = 12'h000, chanAck, chanIrq;
    logic [31:0]      wbDatI = 32'h0, wbDatO, seed = 32'h0000000F, src;
    logic [15:0]      periphReq = 16'h0000;
    logic [1:0]       memReq, memWe, memAck, memErr;
    logic [1:0][31:0] memAddr, memWdata, memRdata;
    logic [63:0]      qw[$]; // expected writes: address, data
    logic [31:0]      qr[$]; // expected register reads
    int               n_errors = 0, n_compared = 0, cyc = 0, t, n;
    dmac_top DUT (.mclk, .reset_n, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel(4'hF), .wbDatI,
        .wbDatO, .wbAck, .periphReq, .syncIn(4'h0), .trigIn(4'h0), .chanAck, .memReq,
        .memWe, .memSize(), .memAddr, .memWdata, .memRdata, .memAck, .memErr, .chanIrq, .irq);
    // first controller answers at once, second after three cycles
    for (genvar c = 0; c < 2; c++) begin : g_mem
        dmac_mem_model #(.LAT(3 * c)) mem (.mclk, .reset_n, .req(memReq[c]), .we(memWe[c]),
            .addr(memAddr[c]), .wdata(memWdata[c]), .rdata(memRdata[c]), .ack(memAck[c]),
            .err(memErr[c]));
    end
    initial forever #20 mclk = ~mclk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic end_sim();
        if (n_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input logic [63:0] e, input logic [63:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    // one classic cycle, entered just after an edge
    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
        {wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {2'b11, we, a, d};
        do @(posedge mclk); while (wbAck !== 1'b1);
        {wbCyc, wbStb} <= 2'b00;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        qr.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask
    // program a channel, config last so it starts with all fields set
    task automatic ch(input int k, input logic [31:0] s, d, c, r, f);
        logic [11:0] b;
        b = dmac_pkg::CH_OFS + dmac_pkg::CH_STRIDE * k[11:0];
        wb(1'b1, b + 12'h004, s);
        wb(1'b1, b + 12'h008, d);
        wb(1'b1, b + 12'h00C, c);
        wb(1'b1, b + 12'h010, r);
        wb(1'b1, b, f);
    endtask
    // results are checked against the oldest note as they appear
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (wbAck === 1'b1 && wbWe === 1'b0) cmp({32'h0, qr.pop_front()}, {32'h0, wbDatO});
        for (int c = 0; c < 2; c++)
            if (memReq[c] && memWe[c] && memAck[c]) cmp(qw.pop_front(), {memAddr[c], memWdata[c]});
        if (cyc == 30000) begin
            n_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rd(12'h000, 32'h0);
        rd(12'h080, 32'h0);
        // memory to memory, four words, software trigger
        wb(1'b1, 12'h010, 32'h7);
        src = {24'h0, 6'(rnd()), 2'b00};
        for (int k = 0; k < 4; k++) qw.push_back({32'h200 + 4 * k, 32'hC0DE0000 + src[9:2] + k});
        ch(0, src, 32'h200, 32'h4, 32'h0, 32'h743);
        while (qw.size() != 0) @(posedge mclk);
        rd(12'h000, 32'h3);
        cmp(64'h1, {63'h0, irq});
        rd(12'h100, 32'h742);
        wb(1'b1, 12'h008, 32'hF);
        rd(12'h000, 32'h0);
        cmp(64'h0, {63'h0, irq});
        // three peripheral requests at once on the second controller
        for (int k = 0; k < 3; k++) begin
            n = (k == 2) ? 7 : 8 + k;
            src = {24'h0, 6'(rnd()), 2'b00};
            qw.push_back({32'h200 + 4 * n, 32'hC0DE0000 + src[9:2]});
            ch(n, src, 32'h200 + 4 * n, 32'h1, k, (k == 2) ? 32'h749 : 32'h759);
        end
        periphReq <= 16'h0007;
        while (qw.size() != 0) @(posedge mclk);
        periphReq <= 16'h0000;
        rd(12'h000, 32'h30000000);
        // faulting source on channel ten
        wb(1'b1, 12'h014, 32'h400);
        ch(10, 32'h80000000, 32'h300, 32'h1, 32'h0, 32'h743);
        t = 0;
        while (irq !== 1'b1 && t++ < 100) @(posedge mclk);
        rd(12'h004, 32'h433);
        rd(12'h240, 32'h742);
        wb(1'b1, 12'h00C, 32'hFFFFFFFF);
        rd(12'h004, 32'h0);
        cmp(64'h0, {63'h0, irq});
        end_sim();
    end
endmodule
`default_nettype wire
